//--- src/usp_cfg.svh
// constants for the unsigned saturating simd and halfword pack datapath
// assumes inclusion by the package and by the datapath modules
`ifndef USP_CFG_SVH
`define USP_CFG_SVH

`define USP_DATA_W 32
`define USP_HALF_W 16
`define USP_BYTE_W 8
`define USP_SHAMT_W 5
`define USP_HALF_LANES 2
`define USP_BYTE_LANES 4
`define USP_HI_LSB 16
`define USP_HI_MSB 31
`define USP_LO_MSB 15
// a zero immediate on pack_top_bottom stands for a shift of this many bits
`define USP_ASR_ZERO_AMT 6'h20
`define USP_RESULT_RST 32'h0000_0000
`define USP_LATENCY 1

`endif

//--- src/usp_pkg.sv
// types for the unsigned saturating simd and halfword pack datapath
// assumes usp_cfg.svh is on the include path
package usp_pkg;
`include "usp_cfg.svh"

    typedef enum logic [2:0] {
        USP_OP_USAT_ADD_SUB_EXCHANGE = 3'h0,
        USP_OP_USAT_SUB_ADD_EXCHANGE = 3'h1,
        USP_OP_USAT_QUAD_BYTE_ADD = 3'h2,
        USP_OP_USAT_DUAL_HALF_ADD = 3'h3,
        USP_OP_USAT_QUAD_BYTE_SUB = 3'h4,
        USP_OP_USAT_DUAL_HALF_SUB = 3'h5,
        USP_OP_PACK_BOTTOM_TOP = 3'h6,
        USP_OP_PACK_TOP_BOTTOM = 3'h7
    } usp_op_t;

    typedef struct packed {
        usp_op_t op;
        logic [`USP_DATA_W-1:0] first_operand_reg;
        logic [`USP_DATA_W-1:0] second_operand_reg;
        logic [`USP_SHAMT_W-1:0] shamt;
        logic cond_pass;
    } usp_req_t;

    typedef struct packed {
        logic [`USP_DATA_W-1:0] result;
        logic wr_en;
        logic flags_we;
    } usp_rsp_t;

endpackage

//--- src/usp_sat_lane.sv
// one unsigned saturating add or subtract lane, purely combinational
// assumes operands are unsigned and the caller selects add or subtract
`timescale 1ns/100ps

module usp_sat_lane
#(
    parameter int W = 16
)
(
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sub,
    output logic [W-1:0] y
);

    logic [W:0] wide;

    always_comb
    begin
        if (sub)
        begin
            wide = {1'b0, a} - {1'b0, b};
        end
        else
        begin
            wide = {1'b0, a} + {1'b0, b};
        end
    end

    // the extra bit is carry on add and borrow on subtract
    always_comb
    begin
        if (!wide[W])
        begin
            y = wide[W-1:0];
        end
        else if (sub)
        begin
            y = '0;
        end
        else
        begin
            y = '1;
        end
    end

endmodule

//--- src/usp_alu.sv
// unsigned saturating simd add/sub and halfword pack datapath, one cycle
// assumes decode supplies operands, shift immediate and condition result
`timescale 1ns/100ps
`include "usp_cfg.svh"

module usp_alu
    import usp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic IN_VALID,
    input wire usp_req_t IN_REQ,
    output logic OUT_VALID,
    output usp_rsp_t OUT_RSP
);

    localparam int HW = `USP_HALF_W;
    localparam int BW = `USP_BYTE_W;

    logic [`USP_DATA_W-1:0] opa;
    logic [`USP_DATA_W-1:0] opb;
    logic [HW-1:0] half_b [`USP_HALF_LANES];
    logic half_sub [`USP_HALF_LANES];
    logic [HW-1:0] half_y [`USP_HALF_LANES];
    logic [BW-1:0] byte_y [`USP_BYTE_LANES];
    logic [`USP_DATA_W-1:0] half_res;
    logic [`USP_DATA_W-1:0] byte_res;
    logic [`USP_DATA_W-1:0] lsl_val;
    logic [`USP_DATA_W-1:0] asr_val;
    logic [5:0] asr_amt;
    logic [`USP_DATA_W-1:0] result_d;
    logic [`USP_DATA_W-1:0] result_q;
    logic valid_q;
    logic wr_en_q;
    logic flags_we_q;
    logic byte_sub;
    logic do_write;

    assign opa = IN_REQ.first_operand_reg;
    assign opb = IN_REQ.second_operand_reg;
    assign byte_sub = (IN_REQ.op == USP_OP_USAT_QUAD_BYTE_SUB);

    // lane 1 is the top halfword; exchange ops cross the second operand halves
    always_comb
    begin
        case (IN_REQ.op)
            USP_OP_USAT_ADD_SUB_EXCHANGE:
            begin
                half_b[1] = opb[`USP_LO_MSB:0];
                half_sub[1] = 1'b0;
                half_b[0] = opb[`USP_HI_MSB:`USP_HI_LSB];
                half_sub[0] = 1'b1;
            end
            USP_OP_USAT_SUB_ADD_EXCHANGE:
            begin
                half_b[1] = opb[`USP_LO_MSB:0];
                half_sub[1] = 1'b1;
                half_b[0] = opb[`USP_HI_MSB:`USP_HI_LSB];
                half_sub[0] = 1'b0;
            end
            USP_OP_USAT_DUAL_HALF_SUB:
            begin
                half_b[1] = opb[`USP_HI_MSB:`USP_HI_LSB];
                half_sub[1] = 1'b1;
                half_b[0] = opb[`USP_LO_MSB:0];
                half_sub[0] = 1'b1;
            end
            default:
            begin
                half_b[1] = opb[`USP_HI_MSB:`USP_HI_LSB];
                half_sub[1] = 1'b0;
                half_b[0] = opb[`USP_LO_MSB:0];
                half_sub[0] = 1'b0;
            end
        endcase
    end

    // saturation to the lane range happens inside each lane
    for (genvar h = 0; h < `USP_HALF_LANES; h++)
    begin : g_half
        usp_sat_lane #(.W(HW)) u_lane (
            .a(opa[h*HW +: HW]),
            .b(half_b[h]),
            .sub(half_sub[h]),
            .y(half_y[h])
        );
        assign half_res[h*HW +: HW] = half_y[h];
    end

    for (genvar k = 0; k < `USP_BYTE_LANES; k++)
    begin : g_byte
        usp_sat_lane #(.W(BW)) u_lane (
            .a(opa[k*BW +: BW]),
            .b(opb[k*BW +: BW]),
            .sub(byte_sub),
            .y(byte_y[k])
        );
        assign byte_res[k*BW +: BW] = byte_y[k];
    end

    // a zero immediate already yields an unshifted value for the left shift
    assign lsl_val = opb << IN_REQ.shamt;
    assign asr_amt = (IN_REQ.shamt == '0) ? `USP_ASR_ZERO_AMT : {1'b0, IN_REQ.shamt};
    assign asr_val = $unsigned($signed(opb) >>> asr_amt);

    always_comb
    begin
        case (IN_REQ.op)
            USP_OP_USAT_QUAD_BYTE_ADD,
            USP_OP_USAT_QUAD_BYTE_SUB:
            begin
                result_d = byte_res;
            end
            USP_OP_PACK_BOTTOM_TOP:
            begin
                result_d = {lsl_val[`USP_HI_MSB:`USP_HI_LSB], opa[`USP_LO_MSB:0]};
            end
            USP_OP_PACK_TOP_BOTTOM:
            begin
                result_d = {opa[`USP_HI_MSB:`USP_HI_LSB], asr_val[`USP_LO_MSB:0]};
            end
            default:
            begin
                result_d = half_res;
            end
        endcase
    end

    assign do_write = IN_VALID && IN_REQ.cond_pass;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            valid_q <= 1'b0;
            flags_we_q <= 1'b0;
        end
        else
        begin
            valid_q <= IN_VALID;
            flags_we_q <= 1'b0;
        end
    end

    // a failed condition keeps the old result so nothing downstream changes
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            result_q <= `USP_RESULT_RST;
            wr_en_q <= 1'b0;
        end
        else
        begin
            wr_en_q <= do_write;
            if (do_write)
            begin
                result_q <= result_d;
            end
        end
    end

    assign OUT_VALID = valid_q;
    assign OUT_RSP.result = result_q;
    assign OUT_RSP.wr_en = wr_en_q;
    // no operation here owns the flags, so the flag write stays low in every slot
    assign OUT_RSP.flags_we = flags_we_q;

    // reference arithmetic for the checks below, kept apart from the lane logic
    function automatic logic [15:0] f_add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16] ? 16'hffff : s[15:0];
    endfunction

    function automatic logic [15:0] f_sub16(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? 16'h0000 : 16'(a - b);
    endfunction

    function automatic logic [7:0] f_add8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8] ? 8'hff : s[7:0];
    endfunction

    function automatic logic [7:0] f_sub8(input logic [7:0] a, input logic [7:0] b);
        return (a < b) ? 8'h00 : 8'(a - b);
    endfunction

    logic [15:0] a_hi, a_lo, b_hi, b_lo, asx_hi, asx_lo, sax_hi, sax_lo;
    logic [31:0] exp_add8, exp_sub8, exp_pkbt, exp_pktb, exp_add16, exp_sub16;
    logic [4:0] sh;

    assign a_hi = opa[31:16];
    assign a_lo = opa[15:0];
    assign b_hi = opb[31:16];
    assign b_lo = opb[15:0];
    assign sh = IN_REQ.shamt;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            exp_add8[i*8 +: 8] = f_add8(opa[i*8 +: 8], opb[i*8 +: 8]);
            exp_sub8[i*8 +: 8] = f_sub8(opa[i*8 +: 8], opb[i*8 +: 8]);
        end
    end

    assign exp_pkbt = {16'((opb << sh) >> 16), a_lo};
    assign exp_pktb = {a_hi, (sh == 5'h00) ? {16{opb[31]}} : 16'($signed(opb) >>> sh)};
    assign asx_hi = f_add16(a_hi, b_lo);
    assign asx_lo = f_sub16(a_lo, b_hi);
    assign sax_hi = f_sub16(a_hi, b_lo);
    assign sax_lo = f_add16(a_lo, b_hi);
    assign exp_add16 = {f_add16(a_hi, b_hi), f_add16(a_lo, b_lo)};
    assign exp_sub16 = {f_sub16(a_hi, b_hi), f_sub16(a_lo, b_lo)};

    logic take;
    assign take = do_write;

    asx_top_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_ADD_SUB_EXCHANGE
        |=> OUT_RSP.result[31:16] == $past(asx_hi))
        else $error("add-sub-exchange top half wrong");

    asx_bottom_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_ADD_SUB_EXCHANGE
        |=> OUT_RSP.result[15:0] == $past(asx_lo))
        else $error("add-sub-exchange bottom half wrong");

    sax_top_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_SUB_ADD_EXCHANGE
        |=> OUT_RSP.result[31:16] == $past(sax_hi))
        else $error("sub-add-exchange top half wrong");

    sax_bottom_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_SUB_ADD_EXCHANGE
        |=> OUT_RSP.result[15:0] == $past(sax_lo))
        else $error("sub-add-exchange bottom half wrong");

    exch_clamp_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_ADD_SUB_EXCHANGE
        && ({1'b0, a_hi} + {1'b0, b_lo}) > 17'h0ffff
        |=> OUT_RSP.result[31:16] == 16'hffff)
        else $error("exchange sum not clamped");

    half_add_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_DUAL_HALF_ADD
        |=> OUT_RSP.result == $past(exp_add16))
        else $error("dual halfword add wrong");

    byte_add_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_QUAD_BYTE_ADD
        |=> OUT_RSP.result == $past(exp_add8))
        else $error("quad byte add wrong");

    half_sub_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_DUAL_HALF_SUB
        |=> OUT_RSP.result == $past(exp_sub16))
        else $error("dual halfword subtract wrong");

    byte_sub_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_QUAD_BYTE_SUB
        |=> OUT_RSP.result == $past(exp_sub8))
        else $error("quad byte subtract wrong");

    sub_floor_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_QUAD_BYTE_SUB && opa[7:0] < opb[7:0]
        |=> OUT_RSP.result[7:0] == 8'h00)
        else $error("byte borrow not forced to zero");

    flags_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        OUT_VALID |-> !OUT_RSP.flags_we)
        else $error("flag write seen");

    pack_bt_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_PACK_BOTTOM_TOP
        |=> OUT_RSP.result == $past(exp_pkbt))
        else $error("pack bottom-top wrong");

    pack_tb_a: assert property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_PACK_TOP_BOTTOM
        |=> OUT_RSP.result == $past(exp_pktb))
        else $error("pack top-bottom wrong");

    cond_hold_a: assert property (@(posedge CLK) disable iff (RST)
        IN_VALID && !IN_REQ.cond_pass
        |=> OUT_VALID && !OUT_RSP.wr_en && $stable(OUT_RSP.result))
        else $error("failed condition changed destination");

    one_cycle_a: assert property (@(posedge CLK) disable iff (RST)
        IN_VALID |=> OUT_VALID ##0 (OUT_RSP.wr_en == $past(IN_REQ.cond_pass)))
        else $error("answer not one cycle after request");

    exch_sat_c: cover property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_SUB_ADD_EXCHANGE && a_hi < b_lo);
    byte_sat_c: cover property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_USAT_QUAD_BYTE_ADD
        && ({1'b0, opa[31:24]} + {1'b0, opb[31:24]}) > 9'h0ff);
    asr_full_c: cover property (@(posedge CLK) disable iff (RST)
        take && IN_REQ.op == USP_OP_PACK_TOP_BOTTOM && sh == 5'h00);
    cond_fail_c: cover property (@(posedge CLK) disable iff (RST)
        IN_VALID && !IN_REQ.cond_pass ##1 take);

endmodule

//--- verification/usp_rf_model.sv
// register file side of the datapath: keeps the destination and the flags
// assumes the datapath answers on OUT_VALID one cycle after each request
`timescale 1ns/100ps

module usp_rf_model
    import usp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic out_valid,
    input wire usp_rsp_t out_rsp,
    output logic [31:0] dest_q,
    output logic [3:0] flags_q
);
    // only a general slot is ever the destination, never sp or pc
    always_ff @(posedge clk)
    begin
        if (rst)
            dest_q <= 32'h0000_0000;
        else if (out_valid && out_rsp.wr_en)
            dest_q <= out_rsp.result;
    end

    // a stray flag write inverts the flags so it cannot go unseen
    always_ff @(posedge clk)
    begin
        if (rst)
            flags_q <= 4'ha;
        else if (out_valid && out_rsp.flags_we)
            flags_q <= ~flags_q;
    end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the saturating simd and pack datapath
// assumes a 200 MHz clock and inputs changed on the falling edge
`timescale 1ns/100ps

module tb_top;
    import usp_pkg::*;
    logic clk;
    logic rst;
    logic in_valid;
    usp_req_t in_req;
    logic out_valid;
    usp_rsp_t out_rsp;
    logic [31:0] rf_dest;
    logic [3:0] rf_flags;
    logic [31:0] held;
    int error_cnt;
    int check_count;

    usp_alu dut(.CLK(clk), .RST(rst), .IN_VALID(in_valid), .IN_REQ(in_req),
        .OUT_VALID(out_valid), .OUT_RSP(out_rsp));
    usp_rf_model rf(.clk(clk), .rst(rst), .out_valid(out_valid), .out_rsp(out_rsp),
        .dest_q(rf_dest), .flags_q(rf_flags));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] sl(input logic [15:0] x, input logic [15:0] y,
        input bit s, input int w);
        int t;
        int m;
        m = (1 << w) - 1;
        t = s ? int'(x) - int'(y) : int'(x) + int'(y);
        if (t < 0)
            t = 0;
        if (t > m)
            t = m;
        return 16'(t);
    endfunction

    function automatic logic [31:0] ref_res(input usp_op_t op, input logic [31:0] a,
        input logic [31:0] b, input logic [4:0] sh);
        logic [31:0] r;
        logic [31:0] bl;
        logic signed [31:0] bs;
        int n;
        bit s;
        s = (op == USP_OP_USAT_QUAD_BYTE_SUB) || (op == USP_OP_USAT_DUAL_HALF_SUB);
        n = (sh == 5'h00) ? 32 : int'(sh);
        bl = b << sh;
        // two steps so a 32 bit shift still fills with the sign
        bs = ($signed(b) >>> (n - 1)) >>> 1;
        case (op)
            USP_OP_USAT_ADD_SUB_EXCHANGE:
                r = {sl(a[31:16], b[15:0], 1'b0, 16), sl(a[15:0], b[31:16], 1'b1, 16)};
            USP_OP_USAT_SUB_ADD_EXCHANGE:
                r = {sl(a[31:16], b[15:0], 1'b1, 16), sl(a[15:0], b[31:16], 1'b0, 16)};
            USP_OP_USAT_DUAL_HALF_ADD, USP_OP_USAT_DUAL_HALF_SUB:
                r = {sl(a[31:16], b[31:16], s, 16), sl(a[15:0], b[15:0], s, 16)};
            USP_OP_PACK_BOTTOM_TOP:
                r = {bl[31:16], a[15:0]};
            USP_OP_PACK_TOP_BOTTOM:
                r = {a[31:16], bs[15:0]};
            default:
                for (int k = 0; k < 4; k++)
                    r[8*k+:8] = 8'(sl(16'(a[8*k+:8]), 16'(b[8*k+:8]), s, 8));
        endcase
        return r;
    endfunction

    task automatic drive(input usp_op_t op, input logic [31:0] a, input logic [31:0] b,
        input logic [4:0] sh, input logic cp);
        in_valid = 1'b1;
        in_req = '{op: op, first_operand_reg: a, second_operand_reg: b, shamt: sh,
            cond_pass: cp};
    endtask

    // checks the answer standing in the cycle after the taking edge
    task automatic look(input logic [31:0] exp, input logic cp);
        chk("out_valid", {31'h0, out_valid}, 32'h1);
        chk("wr_en", {31'h0, out_rsp.wr_en}, {31'h0, cp});
        chk("result", out_rsp.result, exp);
        chk("flags_we", {31'h0, out_rsp.flags_we}, 32'h0);
        if (cp)
            held = exp;
    endtask

    task automatic quiet();
        chk("out_valid idle", {31'h0, out_valid}, 32'h0);
        chk("wr_en idle", {31'h0, out_rsp.wr_en}, 32'h0);
        chk("dest", rf_dest, held);
        chk("flags", {28'h0, rf_flags}, 32'ha);
    endtask

    task automatic one(input usp_op_t op, input logic [31:0] a, input logic [31:0] b,
        input logic [4:0] sh, input logic cp);
        @(negedge clk);
        drive(op, a, b, sh, cp);
        @(negedge clk);
        in_valid = 1'b0;
        look(cp ? ref_res(op, a, b, sh) : held, cp);
        @(negedge clk);
        quiet();
    endtask

    task automatic t_exchange();
        one(USP_OP_USAT_ADD_SUB_EXCHANGE, 32'hfff0_0005, 32'h0020_0010, 5'h00, 1'b1);
        one(USP_OP_USAT_ADD_SUB_EXCHANGE, 32'h1234_8000, 32'h0100_0001, 5'h00, 1'b1);
        one(USP_OP_USAT_SUB_ADD_EXCHANGE, 32'h0005_fff0, 32'h0020_0010, 5'h00, 1'b1);
        one(USP_OP_USAT_SUB_ADD_EXCHANGE, 32'h8000_1000, 32'h0010_0100, 5'h00, 1'b1);
        $display("test exchange done");
    endtask

    task automatic t_lanes();
        for (int op = 2; op < 6; op++)
        begin
            one(usp_op_t'(op), 32'hf080_7f01, 32'h2080_0102, 5'h00, 1'b1);
            one(usp_op_t'(op), 32'h0102_ff7f, 32'h00ff_8080, 5'h00, 1'b1);
        end
        $display("test lanes done");
    endtask

    task automatic t_pack();
        logic [4:0] sh_tab[4] = '{5'h00, 5'h01, 5'h10, 5'h1f};
        foreach (sh_tab[i])
        begin
            one(USP_OP_PACK_BOTTOM_TOP, 32'h1234_5678, 32'h8001_7ffe, sh_tab[i], 1'b1);
            one(USP_OP_PACK_TOP_BOTTOM, 32'h1234_5678, 32'h8001_7ffe, sh_tab[i], 1'b1);
        end
        $display("test pack done");
    endtask

    task automatic t_cond();
        one(USP_OP_USAT_DUAL_HALF_ADD, 32'h0001_0001, 32'h0001_0001, 5'h00, 1'b0);
        one(USP_OP_PACK_TOP_BOTTOM, 32'hffff_ffff, 32'h0000_0000, 5'h00, 1'b0);
        $display("test cond done");
    endtask

    task automatic t_b2b();
        @(negedge clk);
        drive(USP_OP_USAT_QUAD_BYTE_ADD, 32'hff00_ff00, 32'h0101_0101, 5'h00, 1'b1);
        @(negedge clk);
        look(ref_res(USP_OP_USAT_QUAD_BYTE_ADD, 32'hff00_ff00, 32'h0101_0101, 5'h00), 1'b1);
        drive(USP_OP_USAT_QUAD_BYTE_SUB, 32'h0010_0010, 32'h0101_0101, 5'h00, 1'b1);
        @(negedge clk);
        in_valid = 1'b0;
        look(ref_res(USP_OP_USAT_QUAD_BYTE_SUB, 32'h0010_0010, 32'h0101_0101, 5'h00), 1'b1);
        @(negedge clk);
        quiet();
        $display("test back to back done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #(5.0 * 2000);
        error_cnt++;
        results();
    end

    initial
    begin
        rst = 1'b1;
        in_valid = 1'b0;
        in_req = '0;
        held = 32'h0000_0000;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_exchange();
        t_lanes();
        t_pack();
        t_cond();
        t_b2b();
        results();
    end
endmodule
